// file: nvs_top.sv
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "nvs_consts.svh"

// Overview of operation
// - Read opcode drives out addressed 16-bit word
// - First bit on 8th fall, rest rising
// - Write opcode takes next 16 bits
// - Reset clears programming enable latch
// - Writes and stores need enable first
// - Enable holds until disable, store, reset, low supply
// - Disable instruction clears enable latch
// - Reads work regardless of enable latch
// - Recall by instruction or low pin
// - No write or store before recall
// - Finished recall sets previous-recall latch
// - Automatic recall after reset
// - Serial port and store/recall pins ignored during power-up inhibit; Wishbone port still served
// - Store by instruction or low pin
// - Store needs both latches set
// - Store blocks serial and recall; a recall requested in the store's start cycle still starts
// - Finished store clears enable latch
// - Low supply blocks store, clears enable
// - Eight-bit instruction sampled on rising edges
// - Opcode decode table
// - Early enable drop discards instruction
module nvs_top #(
    parameter int unsigned STORE_CYC = `NVS_STORE_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                chip_enable_i,
    input  wire logic                shift_clock_i,
    input  wire logic                serial_in_pin_i,
    output logic                     serial_out_o,
    output logic                     serial_out_oe_n_o,
    input  wire logic                store_n_i,
    input  wire logic                recall_n_i,
    input  wire logic                low_supply_i,
    output nvs_pkg::nvs_flags_t      flags_o
);
    import nvs_pkg::*;

    function automatic logic nvs_is_read(input logic [2:0] op);
        nvs_is_read = (op[2:1] == `NVS_OP_READ_HI);
    endfunction : nvs_is_read

    nvs_ser_t    ser_q;
    logic [4:0]  bit_cnt_q;
    logic [6:0]  sh_q;
    logic [3:0]  addr_q;
    logic [15:0] rd_word_q;
    logic        rd_started_q;
    logic        sck_q;
    logic        store_n_q;
    logic        recall_n_q;
    logic [4:0]  pur_cnt_q;
    logic        pur_done_q;
    logic        prog_en_q;
    logic        prev_recall_q;
    logic        store_busy_q;
    logic        recall_busy_q;
    logic [31:0] tmr_q;
    logic        ser_en_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic        so_q;
    logic        so_oe_n_q;
    logic [15:0] ram_q [16];
    logic [15:0] ee_q  [16];

    logic        sck_rise;
    logic        sck_fall;
    logic [6:0]  instr;
    logic        decode_now;
    logic        wr_done;
    logic [15:0] wr_data;
    logic        cmd_en;
    logic        cmd_dis;
    logic        cmd_save;
    logic        cmd_restore;
    logic        pur_tick;
    logic        store_req;
    logic        store_go;
    logic        store_done;
    logic        recall_go;
    logic        recall_done;
    logic        wr_en;
    logic        ser_hold;

    assign sck_rise   = shift_clock_i & ~sck_q;
    assign sck_fall   = ~shift_clock_i & sck_q;
    assign instr      = {sh_q[5:0], serial_in_pin_i};
    assign ser_hold   = ~chip_enable_i | store_busy_q | ~pur_done_q | ~ser_en_q;
    assign decode_now = (ser_q == NVS_INSTR) & sck_rise & (bit_cnt_q == 5'd7);
    assign cmd_dis     = decode_now & (instr[2:0] == `NVS_OP_DISPROG);
    assign cmd_save    = decode_now & (instr[2:0] == `NVS_OP_SAVE);
    assign cmd_en      = decode_now & (instr[2:0] == `NVS_OP_ENPROG);
    assign cmd_restore = decode_now & (instr[2:0] == `NVS_OP_RESTORE);
    assign wr_data     = {rd_word_q[14:0], serial_in_pin_i};
    assign wr_done     = (ser_q == NVS_WRITE) & sck_rise & (bit_cnt_q == 5'd15);
    assign wr_en       = wr_done & prog_en_q & prev_recall_q & ~store_busy_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q      <= 1'b0;
            store_n_q  <= 1'b1;
            recall_n_q <= 1'b1;
        end else begin
            sck_q      <= shift_clock_i;
            store_n_q  <= store_n_i;
            recall_n_q <= recall_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pur_cnt_q  <= 5'd0;
            pur_done_q <= 1'b0;
        end else if (!pur_done_q) begin
            pur_cnt_q  <= pur_cnt_q + 5'd1;
            pur_done_q <= (pur_cnt_q == 5'(`NVS_PUR_CYC - 1));
        end
    end
    assign pur_tick = ~pur_done_q & (pur_cnt_q == 5'(`NVS_PUR_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || ser_hold) begin
            ser_q        <= NVS_IDLE;
            bit_cnt_q    <= 5'd0;
            sh_q         <= 7'h00;
            addr_q       <= 4'h0;
            rd_word_q    <= 16'h0000;
            rd_started_q <= 1'b0;
        end else begin
            unique case (ser_q)
                NVS_IDLE: begin
                    if (sck_rise && serial_in_pin_i) begin
                        ser_q     <= NVS_INSTR;
                        bit_cnt_q <= 5'd1;
                    end
                end
                NVS_INSTR: begin
                    if (sck_rise) begin
                        sh_q      <= instr;
                        bit_cnt_q <= bit_cnt_q + 5'd1;
                        if (decode_now) begin
                            addr_q    <= instr[6:3];
                            bit_cnt_q <= 5'd0;
                            if (nvs_is_read(instr[2:0])) begin
                                ser_q     <= NVS_READ;
                                rd_word_q <= ram_q[instr[6:3]];
                            end else if (instr[2:0] == `NVS_OP_WRITE) begin
                                ser_q <= NVS_WRITE;
                            end else begin
                                ser_q <= NVS_DONE;
                            end
                        end
                    end
                end
                NVS_READ: begin
                    // first bit on fall, then rising edges
                    if (sck_fall && !rd_started_q) begin
                        rd_started_q <= 1'b1;
                        rd_word_q    <= {rd_word_q[14:0], 1'b0};
                    end else if (sck_rise && rd_started_q) begin
                        rd_word_q <= {rd_word_q[14:0], 1'b0};
                    end
                end
                NVS_WRITE: begin
                    if (sck_rise) begin
                        rd_word_q <= wr_data;
                        bit_cnt_q <= bit_cnt_q + 5'd1;
                        if (wr_done) begin
                            ser_q <= NVS_DONE;
                        end
                    end
                end
                NVS_DONE: begin
                end
            endcase
        end
    end

    // output pin leaves high impedance only in a read
    always_ff @(posedge clk_i) begin
        if (rst_i || ser_hold || ser_q != NVS_READ) begin
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else if ((sck_fall && !rd_started_q) || (sck_rise && rd_started_q)) begin
            so_q      <= rd_word_q[15];
            so_oe_n_q <= 1'b0;
        end
    end

    // pins act on their falling edge, so a held level fires once
    assign store_req  = cmd_save | (~store_n_i & store_n_q);
    // refused store leaves all state alone
    assign store_go   = store_req & prog_en_q & prev_recall_q & ~low_supply_i
                        & ~store_busy_q & ~recall_busy_q & pur_done_q;
    assign recall_go  = (cmd_restore | (~recall_n_i & recall_n_q & pur_done_q) | pur_tick)
                        & ~store_busy_q & ~recall_busy_q;
    assign store_done  = store_busy_q & ~low_supply_i & (tmr_q == STORE_CYC - 1);
    assign recall_done = recall_busy_q & (tmr_q == 32'(`NVS_RECALL_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            store_busy_q  <= 1'b0;
            recall_busy_q <= 1'b0;
            tmr_q         <= 32'h0000_0000;
        end else begin
            tmr_q <= tmr_q + 32'h0000_0001;
            if (store_go || recall_go) begin
                tmr_q <= 32'h0000_0000;
            end
            if (store_go) begin
                store_busy_q <= 1'b1;
            // low supply aborts a store in flight
            end else if (store_done || low_supply_i) begin
                store_busy_q <= 1'b0;
            end
            if (recall_go) begin
                recall_busy_q <= 1'b1;
            end else if (recall_done) begin
                recall_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_en_q <= 1'b0;
        end else if (low_supply_i || store_done || cmd_dis) begin
            prog_en_q <= 1'b0;
        end else if (cmd_en) begin
            prog_en_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_recall_q <= 1'b0;
        end else if (recall_done) begin
            prev_recall_q <= 1'b1;
        end
    end

    // Arrays copy whole at the end of a cycle, so a late abort leaves EEPROM intact
    for (genvar i = 0; i < 16; i++) begin : g_word
        always_ff @(posedge clk_i) begin
            if (recall_done) begin
                ram_q[i] <= ee_q[i];
            end else if (wr_en && addr_q == 4'(i)) begin
                ram_q[i] <= wr_data;
            end
        end
        // Simulation needs a known array, so reset loads a blank image
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ee_q[i] <= `NVS_EE_INIT;
            end else if (store_done) begin
                ee_q[i] <= ram_q[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            dat_q    <= 32'h0000_0000;
            ser_en_q <= `NVS_CTRL_RST;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                dat_q <= 32'h0000_0000;
                if (wb_adr_i[7:2] == `NVS_ADR_STATUS) begin
                    dat_q <= {28'h0000_000, flags_o};
                end else if (wb_adr_i[7:2] == `NVS_ADR_CTRL) begin
                    dat_q <= {31'h0000_0000, ser_en_q};
                    if (wb_we_i && wb_sel_i[0]) begin
                        ser_en_q <= wb_dat_i[0];
                    end
                end
            end
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = dat_q;
    assign serial_out_o      = so_q;
    assign serial_out_oe_n_o = so_oe_n_q;
    assign flags_o           = '{recall_busy: recall_busy_q, store_busy: store_busy_q,
                                 prev_recall: prev_recall_q, prog_en: prog_en_q};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reset_prog: assert property ($past(rst_i) |-> !prog_en_q)
        else $error("enable latch set after reset");
    a_dis_clears: assert property (cmd_dis |=> !prog_en_q)
        else $error("disable did not clear enable latch");
    a_store_clear: assert property (store_done |=> !prog_en_q && !store_busy_q)
        else $error("store end left enable latch set");
    a_low_supply: assert property (low_supply_i |=> !prog_en_q && !store_busy_q)
        else $error("low supply did not stop store");
    a_store_guard: assert property ($rose(store_busy_q) |-> $past(prog_en_q && prev_recall_q))
        else $error("store started without both latches");
    // write guard, a recall landing in the same cycle may change the word
    a_write_guard: assert property (wr_done && !(prog_en_q && prev_recall_q)
        && !recall_done |=> $stable(ram_q[addr_q]))
        else $error("write accepted without both latches");
    a_auto_recall: assert property (pur_tick |-> ##[1:20] prev_recall_q)
        else $error("no recall after power-up");
    a_store_block: assert property (store_busy_q |=> ser_q == NVS_IDLE)
        else $error("serial active during store");
    a_ce_drop: assert property (!chip_enable_i |=> ser_q == NVS_IDLE && bit_cnt_q == 5'd0)
        else $error("instruction kept after enable drop");
    a_read_first: assert property (ser_q == NVS_READ && !rd_started_q && sck_fall
        && chip_enable_i && !ser_hold |=> !serial_out_oe_n_o
        && serial_out_o == $past(rd_word_q[15]))
        else $error("first read bit not driven on fall");
    a_recall_set: assert property (recall_done |=> prev_recall_q [*2])
        else $error("recall did not set latch");
    a_read_next: assert property (ser_q == NVS_READ && rd_started_q && sck_rise
        && !ser_hold |=> !serial_out_oe_n_o && serial_out_o == $past(rd_word_q[15]))
        else $error("read bit not driven on rise");
    a_read_release: assert property (!chip_enable_i |=> serial_out_oe_n_o)
        else $error("output still driven after deselect");
    a_pur_inhibit: assert property (!pur_done_q |-> ser_q == NVS_IDLE && !prog_en_q
        && !store_busy_q)
        else $error("activity during power-up inhibit");
    a_store_refused: assert property (store_req && !store_busy_q
        && !(prog_en_q && prev_recall_q) |=> !store_busy_q)
        else $error("store started without both latches");

    c_read: cover property (ser_q == NVS_READ && rd_started_q);
    c_write: cover property (wr_en);
    c_store: cover property (store_done);
    c_recall: cover property (recall_done && !pur_tick);
    c_pin_store: cover property (store_go && !cmd_save);

endmodule : nvs_top
`default_nettype wire

// file: nvs_consts.svh
`ifndef NVS_CONSTS_SVH
`define NVS_CONSTS_SVH

`define NVS_CLK_MHZ       100
`define NVS_PUR_NS        200
`define NVS_PUR_CYC       ((`NVS_PUR_NS * `NVS_CLK_MHZ + 999) / 1000)
`define NVS_STORE_MS      10
`define NVS_STORE_CYC     (`NVS_STORE_MS * 1000 * 1000 * `NVS_CLK_MHZ / 1000)
`define NVS_RECALL_CYC    16
`define NVS_ADR_STATUS    6'h00
`define NVS_ADR_CTRL      6'h01
`define NVS_CTRL_RST      1'h1
`define NVS_OP_DISPROG    3'h0
`define NVS_OP_SAVE       3'h1
`define NVS_OP_WRITE      3'h3
`define NVS_OP_ENPROG     3'h4
`define NVS_OP_RESTORE    3'h5
`define NVS_OP_READ_HI    2'h3
`define NVS_EE_INIT       16'h0000

`endif

// file: nvs_pkg.sv
package nvs_pkg;
    typedef enum logic [2:0] {
        NVS_IDLE,
        NVS_INSTR,
        NVS_READ,
        NVS_WRITE,
        NVS_DONE
    } nvs_ser_t;

    typedef struct packed {
        logic recall_busy;
        logic store_busy;
        logic prev_recall;
        logic prog_en;
    } nvs_flags_t;
endpackage : nvs_pkg

// file: nvs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module nvs_host_model (
    input  wire logic clk_i,
    input  wire logic serial_out_i,
    output var logic  chip_enable_o,
    output var logic  shift_clock_o,
    output var logic  serial_in_o
);
    initial begin
        chip_enable_o = 1'b0;
        shift_clock_o = 1'b0;
        serial_in_o   = 1'b0;
    end

    // Each level of the shift clock spans four system clocks, above the two-clock minimum
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask : hold

    // Shifts n bits of {instruction, data}; fewer than 8 cuts the frame short
    // start bit, MSB first
    task automatic frame(input logic [7:0] ins, input logic [15:0] wd, input int n,
                         output logic [15:0] rd);
        logic [23:0] sh;
        sh = {ins, wd};
        rd = 16'h0000;
        @(posedge clk_i);
        chip_enable_o <= 1'b1;
        hold(4);
        for (int i = 0; i < n; i++) begin
            shift_clock_o <= 1'b0;
            serial_in_o   <= sh[23 - i];
            hold(4);
            if (i >= 8) begin
                rd = {rd[14:0], serial_out_i};
            end
            shift_clock_o <= 1'b1;
            hold(4);
        end
        shift_clock_o <= 1'b0;
        hold(4);
        chip_enable_o <= 1'b0;
        serial_in_o   <= ~serial_in_o;
        hold(4);
    endtask : frame
endmodule : nvs_host_model
`default_nettype wire

// file: serial_nvram_store_recall_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_nvram_store_recall_tb_top;
    import nvs_pkg::*;
    localparam int unsigned STORE_CYC = 400;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'hF;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rv;
    logic        wb_ack, ce, sk, din, dout, oe_n;
    logic        do_line;
    logic        store_n = 1'b1, recall_n = 1'b1, low_supply = 1'b0;
    nvs_flags_t  flags;
    logic [15:0] rd;
    int          bad_count = 0;
    int          samples_checked = 0;

    always #5 clk_i = ~clk_i;

    // Released output floats to the pull-up level, so an undriven read shows ones
    assign do_line = oe_n ? 1'b1 : dout;

    nvs_top #(.STORE_CYC(STORE_CYC)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .chip_enable_i(ce), .shift_clock_i(sk),
        .serial_in_pin_i(din), .serial_out_o(dout), .serial_out_oe_n_o(oe_n),
        .store_n_i(store_n), .recall_n_i(recall_n), .low_supply_i(low_supply),
        .flags_o(flags)
    );

    nvs_host_model host (
        .clk_i(clk_i), .serial_out_i(do_line), .chip_enable_o(ce),
        .shift_clock_o(sk), .serial_in_o(din)
    );

    task automatic end_of_test;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wb_read(input logic [7:0] adr, output logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= 1'b0;
        wb_adr <= adr;
        for (int k = 0; k <= 50; k++) begin
            @(posedge clk_i);
            if (wb_ack === 1'b1) begin
                break;
            end
            if (k == 50) begin
                chk(1'b0, 1'b1, "bus ack timeout");
                end_of_test();
            end
        end
        dat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_read

    task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= 1'b1;
        wb_adr  <= adr;
        wb_wdat <= dat;
        for (int k = 0; k <= 50; k++) begin
            @(posedge clk_i);
            if (wb_ack === 1'b1) begin
                break;
            end
            if (k == 50) begin
                chk(1'b0, 1'b1, "bus ack timeout");
                end_of_test();
            end
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_write

    task automatic wait_flag(input int idx, input logic val);
        for (int k = 0; k <= 3000; k++) begin
            @(posedge clk_i);
            if (flags[idx] === val) begin
                return;
            end
        end
        chk(1'b0, 1'b1, "flag wait timeout");
        end_of_test();
    endtask : wait_flag

    task automatic cmd(input logic [2:0] op, input logic [3:0] a, input logic [15:0] wd,
                       input int n);
        host.frame({1'b1, a, op}, wd, n, rd);
    endtask : cmd

    task automatic pin_pulse(input bit is_store);
        @(posedge clk_i);
        if (is_store) begin
            store_n <= 1'b0;
        end else begin
            recall_n <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
        store_n  <= 1'b1;
        recall_n <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : pin_pulse

    task automatic t_reset;
        repeat (8) @(posedge clk_i);
        chk(flags, 4'h0, "flags in reset");
        chk(oe_n, 1'b1, "output driven in reset");
        rst_i <= 1'b0;
        wait_flag(3, 1'b1);
        wait_flag(1, 1'b1);
        wb_read(8'h00, rv);
        chk(rv, 32'h2, "status after auto recall");
        wb_read(8'h04, rv);
        chk(rv, 32'h1, "control reset value");
        wb_read(8'h10, rv);
        chk(rv, 32'h0, "unmapped read");
    endtask : t_reset

    task automatic t_read_write;
        cmd(3'h3, 4'h3, 16'hA5C3, 24);
        cmd(3'h6, 4'h3, 16'h0, 24);
        chk(rd, 16'h0000, "write without enable");
        cmd(3'h4, 4'h0, 16'h0, 8);
        chk(flags.prog_en, 1'b1, "enable latch set");
        cmd(3'h3, 4'h3, 16'hA5C3, 24);
        cmd(3'h6, 4'h3, 16'h0, 24);
        chk(rd, 16'hA5C3, "read op 110");
        cmd(3'h7, 4'h3, 16'h0, 24);
        chk(rd, 16'hA5C3, "read op 111 bit order");
        chk(oe_n, 1'b1, "output released after frame");
        chk(flags.prog_en, 1'b1, "enable held");
    endtask : t_read_write

    task automatic t_disable;
        cmd(3'h0, 4'h0, 16'h0, 8);
        chk(flags.prog_en, 1'b0, "disable clears latch");
        cmd(3'h3, 4'h3, 16'h1234, 24);
        cmd(3'h6, 4'h3, 16'h0, 24);
        chk(rd, 16'hA5C3, "read while disabled");
        cmd(3'h4, 4'h0, 16'h0, 5);
        chk(flags.prog_en, 1'b0, "short frame discarded");
        wb_write(8'h04, 32'h0);
        cmd(3'h4, 4'h0, 16'h0, 8);
        chk(flags.prog_en, 1'b0, "frame ignored with port off");
        wb_read(8'h04, rv);
        chk(rv, 32'h0, "control write lands");
        wb_write(8'h04, 32'h1);
    endtask : t_disable

    task automatic t_store;
        cmd(3'h4, 4'h0, 16'h0, 8);
        cmd(3'h1, 4'h0, 16'h0, 8);
        chk(flags.store_busy, 1'b1, "software store running");
        cmd(3'h3, 4'h3, 16'h1111, 24);
        wait_flag(2, 1'b0);
        chk(flags.prog_en, 1'b0, "store clears enable");
        cmd(3'h4, 4'h0, 16'h0, 8);
        cmd(3'h3, 4'h3, 16'h0F0F, 24);
        cmd(3'h5, 4'h0, 16'h0, 8);
        repeat (20) @(posedge clk_i);
        cmd(3'h6, 4'h3, 16'h0, 24);
        chk(rd, 16'hA5C3, "recall restores stored word");
    endtask : t_store

    task automatic t_pins;
        cmd(3'h0, 4'h0, 16'h0, 8);
        pin_pulse(1'b1);
        chk(flags.store_busy, 1'b0, "pin store refused");
        chk(flags.prev_recall, 1'b1, "refused store keeps latch");
        pin_pulse(1'b0);
        chk(flags.recall_busy, 1'b1, "pin recall running");
        wait_flag(3, 1'b0);
        cmd(3'h4, 4'h0, 16'h0, 8);
        pin_pulse(1'b1);
        chk(flags.store_busy, 1'b1, "pin store running");
        wait_flag(2, 1'b0);
        cmd(3'h4, 4'h0, 16'h0, 8);
        low_supply <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(flags.prog_en, 1'b0, "low supply clears enable");
        pin_pulse(1'b1);
        chk(flags.store_busy, 1'b0, "low supply blocks store");
        low_supply <= 1'b0;
    endtask : t_pins

    initial begin
        t_reset();
        t_read_write();
        t_disable();
        t_store();
        t_pins();
        end_of_test();
    end
endmodule : serial_nvram_store_recall_tb_top
`default_nettype wire
